// ==== logic/emsc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - latch clock source strap after reset
// - divided clock is input over one, two, four
// - full-rate clock matches chosen input clock
// - read strobe serves async, sdram, sync
// - select field picks address or read strobe for sync type
// - output strobe shared across memory types
// - write strobe shared across memory types
// - clock gate controls self-refresh or general output
// - dedicated output strobe for fifo space of sync type
// - ready input paces asynchronous accesses
// - address pins carry doubleword address
// - strap 00 ext, 01 div4, 10 div6
// - exactly one space select per access
module emsc_top (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // clock pins and strap
    input wire logic ext_input_clock_in,
    input wire logic [1:0] input_clock_select_in,
    input wire logic [1:0] clock_ratio_in,
    output logic full_rate_output_clock_out,
    output logic divided_output_clock_out,
    output logic [1:0] clock_source_out,
    // core access request
    input wire logic access_active_in,
    input wire logic [31:0] byte_address_in,
    input wire logic read_req_in,
    input wire logic addr_strobe_req_in,
    input wire logic output_req_in,
    input wire logic write_req_in,
    // per-space configuration
    input wire logic [3:0][1:0] space_mem_type_in,
    input wire logic [3:0] read_strobe_select_in,
    // sdram clock gate control
    input wire logic sdram_fitted_in,
    input wire logic self_refresh_in,
    input wire logic gp_output_in,
    // ready pin and pacing
    input wire logic async_ready_in,
    output logic async_ready_out,
    output logic async_wait_out,
    // memory pins
    output logic [emsc_pkg::ADDR_MSB:emsc_pkg::ADDR_LSB] ext_address_bus_out,
    output logic ext_address_oe_out,
    output logic [3:0] space_select_n_out,
    output logic read_strobe_n_out,
    output logic output_strobe_n_out,
    output logic write_strobe_n_out,
    output logic fifo_space_output_strobe_n_out,
    output logic sdram_clock_gate_out
);
    // strap decode, reserved code falls back to external clock
    function automatic emsc_pkg::emsc_src_t decode_strap(input logic [1:0] code);
        unique case (code)
            emsc_pkg::STRAP_DIV4: decode_strap = emsc_pkg::EMSC_SRC_DIV4;
            emsc_pkg::STRAP_DIV6: decode_strap = emsc_pkg::EMSC_SRC_DIV6;
            default: decode_strap = emsc_pkg::EMSC_SRC_EXT;
        endcase
    endfunction : decode_strap

    emsc_clk_if clk_bus(); // carrier to the clock generator
    emsc_pkg::emsc_src_t src_ff; // latched clock source
    logic strap_done_ff; // strap has been captured
    logic [2:0] rdy_sync_ff; // ready pin synchroniser
    logic ready_ff; // filtered ready level
    logic busy_ff; // an access is in progress
    logic [1:0] mode_ff; // memory type latched for the access
    logic ren_ff; // read strobe select latched for the access
    logic [1:0] space_ff; // chip space latched for the access
    logic [1:0] space; // space decoded from the address
    logic [1:0] cur_mode; // type in force this cycle
    logic cur_ren; // select in force this cycle
    logic [1:0] cur_space; // space in force this cycle
    logic nxt_read_n;
    logic [emsc_pkg::ADDR_MSB:emsc_pkg::ADDR_LSB] addr_ff;
    logic [3:0] sel_n_ff;
    logic read_n_ff;
    logic oe_n_ff;
    logic we_n_ff;
    logic fifo_oe_n_ff;
    logic cke_ff;

    // clock generator
    emsc_clk_gen u_clk_gen (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .ext_input_clock_in(ext_input_clock_in),
        .clk_bus(clk_bus)
    );
    assign clk_bus.src = src_ff;
    assign clk_bus.ratio = clock_ratio_in;
    assign full_rate_output_clock_out = clk_bus.full_clk;
    assign divided_output_clock_out = clk_bus.div_clk;
    assign clock_source_out = src_ff;

    // catch the strap in the first cycle after reset release
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            src_ff <= emsc_pkg::EMSC_SRC_EXT;
            strap_done_ff <= 1'b0;
        end else if (!strap_done_ff) begin
            src_ff <= decode_strap(input_clock_select_in);
            strap_done_ff <= 1'b1;
        end
    end

    // ready pin synchroniser
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            rdy_sync_ff <= 3'h0;
        end else begin
            rdy_sync_ff <= {rdy_sync_ff[1:0], async_ready_in};
        end
    end

    // accept a ready change once stages two and three agree
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ready_ff <= 1'b0;
        end else if (rdy_sync_ff[1] == rdy_sync_ff[2]) begin
            ready_ff <= rdy_sync_ff[2];
        end
    end

    // access context is latched at the start and held to the end
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            busy_ff <= 1'b0;
            mode_ff <= emsc_pkg::MEM_ASYNC;
            ren_ff <= 1'b0;
            space_ff <= 2'h0;
        end else begin
            busy_ff <= access_active_in;
            if (access_active_in && !busy_ff) begin
                mode_ff <= space_mem_type_in[space];
                ren_ff <= read_strobe_select_in[space];
                space_ff <= space;
            end
        end
    end

    // context in force: live at the first cycle, latched afterwards
    always_comb begin
        space = byte_address_in[emsc_pkg::SPACE_LSB +: 2];
        cur_space = busy_ff ? space_ff : space;
        cur_mode = busy_ff ? mode_ff : space_mem_type_in[space];
        cur_ren = busy_ff ? ren_ff : read_strobe_select_in[space];
        // shared read strobe function by memory type
        if (cur_mode == emsc_pkg::MEM_SYNC && !cur_ren) begin
            nxt_read_n = ~addr_strobe_req_in;
        end else begin
            nxt_read_n = ~read_req_in;
        end
    end

    // shared strobes, idle when no access is active
    always_ff @(posedge clock_in) begin
        if (rst_in || !access_active_in) begin
            read_n_ff <= emsc_pkg::STROBE_IDLE;
            oe_n_ff <= emsc_pkg::STROBE_IDLE;
            we_n_ff <= emsc_pkg::STROBE_IDLE;
            fifo_oe_n_ff <= emsc_pkg::STROBE_IDLE;
        end else begin
            read_n_ff <= nxt_read_n;
            oe_n_ff <= ~output_req_in;
            we_n_ff <= ~write_req_in;
            // fifo strobe only for synchronous type in the fifo space
            fifo_oe_n_ff <= ~(output_req_in && cur_space == emsc_pkg::FIFO_SPACE
                              && cur_mode == emsc_pkg::MEM_SYNC);
        end
    end

    // space selects and doubleword address
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            sel_n_ff <= emsc_pkg::SELECT_IDLE;
            addr_ff <= '0;
        end else begin
            sel_n_ff <= access_active_in ? ~(4'h1 << cur_space) : emsc_pkg::SELECT_IDLE;
            addr_ff <= byte_address_in[emsc_pkg::ADDR_MSB:emsc_pkg::ADDR_LSB];
        end
    end

    // clock gate: self-refresh control or general output
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cke_ff <= 1'b1;
        end else begin
            cke_ff <= sdram_fitted_in ? ~self_refresh_in : gp_output_in;
        end
    end

    // outputs
    assign ext_address_bus_out = addr_ff;
    assign ext_address_oe_out = strap_done_ff; // strap pins released first
    assign space_select_n_out = sel_n_ff;
    assign read_strobe_n_out = read_n_ff;
    assign output_strobe_n_out = oe_n_ff;
    assign write_strobe_n_out = we_n_ff;
    assign fifo_space_output_strobe_n_out = fifo_oe_n_ff;
    assign sdram_clock_gate_out = cke_ff;
    assign async_ready_out = ready_ff;
    assign async_wait_out = busy_ff && mode_ff == emsc_pkg::MEM_ASYNC && !ready_ff;

    // source stays fixed once captured
    property p_strap_hold;
        @(posedge clock_in) disable iff (rst_in)
        $past(strap_done_ff) |-> $stable(src_ff);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("clock source changed after strap");

    // one space select during an access, none otherwise
    property p_one_space;
        @(posedge clock_in) disable iff (rst_in)
        access_active_in |-> ##1 $countones(~space_select_n_out) == 1;
    endproperty
    a_one_space: assert property (p_one_space) else $error("space select not one-hot");

    // strobes idle after an idle cycle
    property p_idle;
        @(posedge clock_in) disable iff (rst_in)
        !access_active_in |-> ##1 (read_strobe_n_out && output_strobe_n_out && write_strobe_n_out
                                    && fifo_space_output_strobe_n_out && space_select_n_out == 4'hf);
    endproperty
    a_idle: assert property (p_idle) else $error("strobe active while idle");

    // sync read-enable mode follows the read request
    property p_ren_read;
        @(posedge clock_in) disable iff (rst_in)
        (access_active_in && cur_mode == emsc_pkg::MEM_SYNC && cur_ren) |-> ##1 read_strobe_n_out == !$past(read_req_in);
    endproperty
    a_ren_read: assert property (p_ren_read) else $error("read enable mode wrong");

    // sync address-strobe mode follows the address strobe request
    property p_ren_addr;
        @(posedge clock_in) disable iff (rst_in)
        (access_active_in && cur_mode == emsc_pkg::MEM_SYNC && !cur_ren)
            |-> ##1 read_strobe_n_out == !$past(addr_strobe_req_in);
    endproperty
    a_ren_addr: assert property (p_ren_addr) else $error("address strobe mode wrong");

    // fifo strobe only in the fifo space
    property p_fifo;
        @(posedge clock_in) disable iff (rst_in)
        !fifo_space_output_strobe_n_out |-> $past(cur_space) == emsc_pkg::FIFO_SPACE && !output_strobe_n_out;
    endproperty
    a_fifo: assert property (p_fifo) else $error("fifo strobe outside its space");

    // address pins carry the doubleword address one cycle later
    property p_addr;
        @(posedge clock_in) disable iff (rst_in)
        1'b1 |-> ##1 ext_address_bus_out == $past(byte_address_in[emsc_pkg::ADDR_MSB:emsc_pkg::ADDR_LSB]);
    endproperty
    a_addr: assert property (p_addr) else $error("address pins wrong");

    // clock gate follows self-refresh when sdram fitted
    property p_cke;
        @(posedge clock_in) disable iff (rst_in)
        sdram_fitted_in |-> ##1 sdram_clock_gate_out == !$past(self_refresh_in);
    endproperty
    a_cke: assert property (p_cke) else $error("clock gate wrong");
endmodule : emsc_top
`default_nettype wire

// ==== common/emsc_pkg.sv ====
`default_nettype none
// shared constants for the external memory strobe and clock layer
package emsc_pkg;
    // strap codes on the clock select pins
    localparam logic [1:0] STRAP_EXT = 2'h0;
    localparam logic [1:0] STRAP_DIV4 = 2'h1;
    localparam logic [1:0] STRAP_DIV6 = 2'h2;
    // core clock periods of the internal sources, in core cycles
    localparam logic [2:0] DIV4_PERIOD = 3'h4;
    localparam logic [2:0] DIV6_PERIOD = 3'h6;
    // divided output clock ratio codes
    localparam logic [1:0] RATIO_1 = 2'h0;
    localparam logic [1:0] RATIO_2 = 2'h1;
    localparam logic [1:0] RATIO_4 = 2'h2;
    // memory type codes of a chip space
    localparam logic [1:0] MEM_ASYNC = 2'h0;
    localparam logic [1:0] MEM_SDRAM = 2'h1;
    localparam logic [1:0] MEM_SYNC = 2'h2;
    // address layout
    localparam int SPACE_LSB = 28;
    localparam int ADDR_LSB = 3;
    localparam int ADDR_MSB = 22;
    localparam logic [1:0] FIFO_SPACE = 2'h3;
    // reset and idle values
    localparam logic STROBE_IDLE = 1'b1;
    localparam logic [3:0] SELECT_IDLE = 4'hf;
    // interface input clock source
    typedef enum logic [1:0] {EMSC_SRC_EXT, EMSC_SRC_DIV4, EMSC_SRC_DIV6} emsc_src_t;
endpackage : emsc_pkg
`default_nettype wire

// ==== common/emsc_clk_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// carries source choice down and derived clocks back up
interface emsc_clk_if;
    emsc_pkg::emsc_src_t src; // chosen input clock source
    logic [1:0] ratio; // divided clock ratio code
    logic full_clk; // full-rate clock level
    logic div_clk; // divided clock level
    modport gen (input src, input ratio, output full_clk, output div_clk);
    modport user (output src, output ratio, input full_clk, input div_clk);
endinterface : emsc_clk_if
`default_nettype wire

// ==== logic/emsc_clk_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
// builds the full-rate and divided output clocks from the chosen source
module emsc_clk_gen (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // external clock pin
    input wire logic ext_input_clock_in,
    // link to the top
    emsc_clk_if.gen clk_bus
);
    // period of an internal source
    function automatic logic [2:0] period_of(input emsc_pkg::emsc_src_t s);
        period_of = (s == emsc_pkg::EMSC_SRC_DIV6) ? emsc_pkg::DIV6_PERIOD : emsc_pkg::DIV4_PERIOD;
    endfunction : period_of

    logic [2:0] ext_sync_ff; // three-stage pin synchroniser
    logic ext_level_ff; // filtered external level
    logic [2:0] cnt_ff; // internal divider phase
    logic full_ff; // full-rate clock
    logic div_ff; // divided clock
    logic div_ph_ff; // half-rate phase for ratio four
    logic [2:0] nxt_cnt;
    logic nxt_full;
    logic rise;
    emsc_pkg::emsc_src_t src_q_ff; // source seen one cycle ago

    // synchronise the external clock pin
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ext_sync_ff <= 3'h0;
        end else begin
            ext_sync_ff <= {ext_sync_ff[1:0], ext_input_clock_in};
        end
    end

    // accept a new level only when stages two and three agree
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ext_level_ff <= 1'b0;
        end else if (ext_sync_ff[1] == ext_sync_ff[2]) begin
            ext_level_ff <= ext_sync_ff[2];
        end
    end

    // next phase and level of the full-rate clock
    always_comb begin
        // restart the phase on a source change, so no runt high pulse follows the strap
        nxt_cnt = (clk_bus.src != src_q_ff || cnt_ff >= period_of(clk_bus.src) - 3'h1) ? 3'h0 : cnt_ff + 3'h1;
        if (clk_bus.src == emsc_pkg::EMSC_SRC_EXT) begin
            nxt_full = ext_level_ff;
        end else begin
            nxt_full = (nxt_cnt < (period_of(clk_bus.src) >> 1));
        end
        rise = nxt_full & ~full_ff;
    end

    // internal divider and full-rate register
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cnt_ff <= 3'h0;
            full_ff <= 1'b0;
            src_q_ff <= emsc_pkg::EMSC_SRC_EXT;
        end else begin
            cnt_ff <= nxt_cnt;
            full_ff <= nxt_full;
            src_q_ff <= clk_bus.src;
        end
    end

    // divided clock: follows, or toggles on every or every second rise
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            div_ff <= 1'b0;
            div_ph_ff <= 1'b0;
        end else if (clk_bus.ratio == emsc_pkg::RATIO_2) begin
            div_ff <= rise ? ~div_ff : div_ff;
        end else if (clk_bus.ratio == emsc_pkg::RATIO_4) begin
            if (rise) begin
                div_ph_ff <= ~div_ph_ff;
                div_ff <= div_ph_ff ? ~div_ff : div_ff;
            end
        end else begin
            div_ff <= nxt_full;
        end
    end

    assign clk_bus.full_clk = full_ff;
    assign clk_bus.div_clk = div_ff;

    // divide-by-six clock stays high three cycles
    property p_div6_high;
        @(posedge clock_in) disable iff (rst_in)
        (clk_bus.src == emsc_pkg::EMSC_SRC_DIV6 && $stable(clk_bus.src) && $rose(full_ff))
            |-> full_ff[*3] ##1 !full_ff;
    endproperty
    a_div6_high: assert property (p_div6_high) else $error("div6 clock high time wrong");

    // divide-by-four clock repeats every four cycles
    property p_div4_period;
        @(posedge clock_in) disable iff (rst_in)
        (clk_bus.src == emsc_pkg::EMSC_SRC_DIV4 && $stable(clk_bus.src) && $rose(full_ff))
            |-> ##4 $rose(full_ff);
    endproperty
    a_div4_period: assert property (p_div4_period) else $error("div4 clock period wrong");

    // external source: full-rate clock tracks the agreed pin level
    property p_ext_follow;
        @(posedge clock_in) disable iff (rst_in)
        (clk_bus.src == emsc_pkg::EMSC_SRC_EXT && ext_sync_ff[1] == ext_sync_ff[2])
            ##1 (clk_bus.src == emsc_pkg::EMSC_SRC_EXT)
            |-> ##1 full_ff == $past(ext_sync_ff[2], 2);
    endproperty
    a_ext_follow: assert property (p_ext_follow) else $error("full clock not tracking pin");

    // ratio one: divided clock equals full-rate clock
    property p_ratio1;
        @(posedge clock_in) disable iff (rst_in)
        (clk_bus.ratio == emsc_pkg::RATIO_1 && $past(clk_bus.ratio) == emsc_pkg::RATIO_1) |-> div_ff == full_ff;
    endproperty
    a_ratio1: assert property (p_ratio1) else $error("ratio one clock mismatch");

    // ratio two: divided clock changes only on a full-rate rise
    property p_ratio2;
        @(posedge clock_in) disable iff (rst_in)
        (clk_bus.ratio == emsc_pkg::RATIO_2 && $past(clk_bus.ratio) == emsc_pkg::RATIO_2 && $changed(div_ff))
            |-> $rose(full_ff);
    endproperty
    a_ratio2: assert property (p_ratio2) else $error("ratio two toggled off a rise");
endmodule : emsc_clk_gen
`default_nettype wire

// ==== test/emsc_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// far side: ready pin of an asynchronous memory and the board interface clock
module emsc_mem_model (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // pins from the block
    input wire logic read_strobe_n_in,
    // behaviour control from the bench
    input wire logic [3:0] wait_cycles_in,
    // pins to the block
    output logic async_ready_out,
    output var logic ext_input_clock_out
);
    logic [3:0] wait_ff; // cycles left before the memory is ready
    logic strobe_ff; // read strobe level one cycle ago

    // free-running board oscillator, 16 core cycles, phase unrelated to the core
    initial begin
        ext_input_clock_out = 1'b0;
        #13;
        forever #400 ext_input_clock_out = ~ext_input_clock_out;
    end

    // ready held low for the programmed wait after each falling read strobe
    always_ff @(posedge clock_in) begin
        strobe_ff <= read_strobe_n_in;
        if (rst_in) begin
            wait_ff <= 4'h0;
        end else if (strobe_ff && !read_strobe_n_in) begin
            wait_ff <= wait_cycles_in;
        end else if (wait_ff != 4'h0) begin
            wait_ff <= wait_ff - 4'h1;
        end
    end

    // pull-up leaves the pin high whenever the memory is not stalling
    assign async_ready_out = (wait_ff == 4'h0);
endmodule : emsc_mem_model
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the strobe and clock layer
module testbench;
    // expected pin levels of one access
    typedef struct packed {
        logic [3:0] sel_n;
        logic rd_n;
        logic oe_n;
        logic wr_n;
        logic fifo_n;
        logic [19:0] addr;
    } emsc_note_t;

    logic clock_in = 1'b0, rst_in = 1'b1; // core clock and reset
    logic ext_clk, ready_pin; // model pins
    logic [1:0] strap = 2'h0, ratio = 2'h0; // strap and ratio code
    logic act = 1'b0, rd = 1'b0, as = 1'b0, oe = 1'b0, wr = 1'b0; // core requests
    logic [31:0] baddr = 32'h0; // byte address
    logic [3:0][1:0] mtype = '0; // per-space memory type
    logic [3:0] rsel = 4'h0; // per-space read strobe select
    logic fitted = 1'b0, srefresh = 1'b0, gpo = 1'b0; // clock gate controls
    logic [3:0] wait_cyc = 4'h0; // model stall length
    logic full_clk, div_clk, rdy_out, wait_out, addr_oe, rd_n, oe_n, wr_n, fifo_n, cke;
    logic [1:0] src;
    logic [19:0] addr_pins;
    logic [3:0] sel_n;
    emsc_note_t notes[$]; // expected results in issue order
    int n_fail = 0, samples_checked = 0; // tallies

    // core clock, 50 ns period
    always #25 clock_in = ~clock_in;

    emsc_top u_emsc_top (.clock_in(clock_in), .rst_in(rst_in), .ext_input_clock_in(ext_clk),
        .input_clock_select_in(strap), .clock_ratio_in(ratio), .full_rate_output_clock_out(full_clk),
        .divided_output_clock_out(div_clk), .clock_source_out(src), .access_active_in(act),
        .byte_address_in(baddr), .read_req_in(rd), .addr_strobe_req_in(as), .output_req_in(oe),
        .write_req_in(wr), .space_mem_type_in(mtype), .read_strobe_select_in(rsel),
        .sdram_fitted_in(fitted), .self_refresh_in(srefresh), .gp_output_in(gpo),
        .async_ready_in(ready_pin), .async_ready_out(rdy_out), .async_wait_out(wait_out),
        .ext_address_bus_out(addr_pins), .ext_address_oe_out(addr_oe), .space_select_n_out(sel_n),
        .read_strobe_n_out(rd_n), .output_strobe_n_out(oe_n), .write_strobe_n_out(wr_n),
        .fifo_space_output_strobe_n_out(fifo_n), .sdram_clock_gate_out(cke));

    emsc_mem_model u_emsc_mem_model (.clock_in(clock_in), .rst_in(rst_in), .read_strobe_n_in(rd_n),
        .wait_cycles_in(wait_cyc), .async_ready_out(ready_pin), .ext_input_clock_out(ext_clk));

    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    // one comparison with report
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (exp !== got) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // bounded wait ran out
    task automatic hang(input string what);
        n_fail++;
        $display("CHECK FAILED %s expected event seen timeout", what);
        stop_test();
    endtask : hang

    // step to just after the n-th rising edge from now
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : tick

    // reset with a given strap on the clock select pins
    task automatic do_reset(input logic [1:0] s);
        rst_in = 1'b1;
        strap = s;
        tick(20);
        rst_in = 1'b0;
        tick(3);
    endtask : do_reset

    // core cycles between rising edges of the full or divided clock
    task automatic meas(input bit use_div, output int p);
        int t, k, last, prev_rise;
        logic prev, cur;
        k = 0;
        last = 0;
        prev_rise = 0;
        prev = use_div ? div_clk : full_clk;
        for (t = 0; t < 400 && k < 3; t++) begin
            @(posedge clock_in);
            cur = use_div ? div_clk : full_clk;
            if (cur && !prev) begin
                prev_rise = last;
                last = t;
                k++;
            end
            prev = cur;
        end
        if (k < 3) hang("clock edge");
        p = last - prev_rise;
        #1;
    endtask : meas

    // one access: note expected pins, drive, hold, release, check idle
    task automatic access(input logic [1:0] s, input bit slow);
        emsc_note_t n;
        int t;
        logic [1:0] ty;
        baddr = $urandom;
        baddr[29:28] = s;
        {rd, as, oe, wr} = 4'($urandom);
        if (slow) rd = 1'b1; // a read is what makes the memory stall
        ty = mtype[s];
        n.sel_n = ~(4'h1 << s);
        n.addr = baddr[22:3];
        n.rd_n = (ty == emsc_pkg::MEM_SYNC && !rsel[s]) ? !as : !rd;
        n.oe_n = !oe;
        n.wr_n = !wr;
        n.fifo_n = (s == emsc_pkg::FIFO_SPACE && ty == emsc_pkg::MEM_SYNC) ? !oe : 1'b1;
        notes.push_back(n);
        act = 1'b1;
        tick(4);
        if (slow) begin
            for (t = 0; t < 30 && wait_out !== 1'b1; t++) tick(1);
            if (wait_out !== 1'b1) hang("async_wait_out rise");
            check("async_wait_out", 32'h1, wait_out);
            for (t = 0; t < 40 && wait_out !== 1'b0; t++) tick(1);
            if (wait_out !== 1'b0) hang("async_wait_out fall");
            check("async_ready_out", 32'h1, rdy_out);
        end else begin
            check("async_wait_out", 32'h0, wait_out);
        end
        act = 1'b0;
        tick(3);
        check("idle strobes", {4'hf, 4'hf}, {sel_n, rd_n, oe_n, wr_n, fifo_n});
    endtask : access

    // watcher: compares pins against the oldest note once an access shows
    initial begin
        emsc_note_t n;
        int t;
        forever begin
            @(posedge clock_in);
            if (sel_n !== emsc_pkg::SELECT_IDLE && !rst_in) begin
                repeat (2) @(posedge clock_in);
                #1;
                if (notes.size() == 0) hang("note queue");
                n = notes.pop_front();
                check("space_select_n_out", n.sel_n, sel_n);
                check("read_strobe_n_out", n.rd_n, rd_n);
                check("output_strobe_n_out", n.oe_n, oe_n);
                check("write_strobe_n_out", n.wr_n, wr_n);
                check("fifo_space_output_strobe_n_out", n.fifo_n, fifo_n);
                check("ext_address_bus_out", n.addr, addr_pins);
                for (t = 0; t < 100 && sel_n !== emsc_pkg::SELECT_IDLE; t++) tick(1);
                if (sel_n !== emsc_pkg::SELECT_IDLE) hang("space select release");
            end
        end
    end

    // main sequence
    initial begin
        int p, pf, i, want;
        void'($urandom(32'h8bb27b14));
        for (i = 0; i < 4; i++) begin
            do_reset(2'(i));
            check("clock_source_out", (i == 3) ? 0 : i, src);
            check("ext_address_oe_out", 32'h1, addr_oe);
            ratio = emsc_pkg::RATIO_1;
            meas(1'b0, pf);
            want = (i == 1) ? 4 : (i == 2) ? 6 : 16;
            check("full clock period", want, pf);
            for (int k = 0; k < 3; k++) begin
                ratio = 2'(k);
                meas(1'b1, p);
                meas(1'b1, p);
                check("divided clock period", want << k, p);
            end
        end
        $display("test clock selection done");
        for (i = 0; i < 40; i++) begin
            mtype = {2'($urandom_range(2, 0)), 2'($urandom_range(2, 0)), 2'($urandom_range(2, 0)),
                2'($urandom_range(2, 0))};
            rsel = 4'($urandom);
            access(2'(i % 4), 1'b0);
        end
        $display("test strobe mapping done");
        for (i = 0; i < 8; i++) begin
            {fitted, srefresh, gpo} = 3'(i);
            tick(2);
            check("sdram_clock_gate_out", fitted ? !srefresh : gpo, cke);
        end
        $display("test clock gate done");
        mtype[0] = emsc_pkg::MEM_ASYNC;
        wait_cyc = 4'h8;
        rd = 1'b1;
        access(2'h0, 1'b1);
        wait_cyc = 4'h0;
        $display("test ready pacing done");
        tick(2);
        check("note queue empty", 32'h0, notes.size());
        stop_test();
    end
endmodule : testbench
`default_nettype wire
